// ---- rtl/icf_top.sv ----
// Top: iso context interrupt flags with register port and summary outputs
`timescale 1ns/100ps
`default_nettype none
module icf_top import icf_pkg::*; (
	input  wire logic        clock_i,      // 200 MHz clock
	input  wire logic        rst_b_i,      // Async reset, active low
	input  wire logic [7:0]  addr_i,       // Register byte address
	input  wire logic [31:0] wdata_i,      // Write data
	input  wire logic        wr_i,         // Write strobe
	input  wire logic        rd_i,         // Read strobe
	output logic      [31:0] rdata_o,      // Read data, cycle after rd_i
	input  wire logic [7:0]  tx_irq_i,     // Tx context irq on last-output done
	input  wire logic [3:0]  rx_irq_i,     // Rx context irq on input done
	output logic             tx_summary_irq_o, // Masked tx summary
	output logic             rx_summary_irq_o, // Masked rx summary
	output logic [7:0]       main_sum_o,   // Summaries at bits 6 and 7
	output logic             irq_o         // Block interrupt
);

	////////////////////////////////////////////////////////////////////////////
	// Bus decode

	icf_bus_s bus;
	assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	logic [7:0] tx_ev_set, tx_ev_clr, tx_mk_set, tx_mk_clr;
	logic [3:0] rx_ev_set, rx_ev_clr, rx_mk_set, rx_mk_clr;
	logic [1:0] st_clr_w;
	logic       mk_wr;

	// Write strobes per register, upper bits dropped
	always_comb begin
		tx_ev_set = '0;
		tx_ev_clr = '0;
		tx_mk_set = '0;
		tx_mk_clr = '0;
		rx_ev_set = '0;
		rx_ev_clr = '0;
		rx_mk_set = '0;
		rx_mk_clr = '0;
		st_clr_w  = '0;
		mk_wr     = 1'b0;
		if (bus.wr) begin
			if (bus.addr == ICF_TX_EV_SET) begin
				tx_ev_set = bus.wdata[7:0];
			end else if (bus.addr == ICF_TX_EV_CLR) begin
				tx_ev_clr = bus.wdata[7:0];
			end else if (bus.addr == ICF_TX_MK_SET) begin
				tx_mk_set = bus.wdata[7:0];
			end else if (bus.addr == ICF_TX_MK_CLR) begin
				tx_mk_clr = bus.wdata[7:0];
			end else if (bus.addr == ICF_RX_EV_SET) begin
				rx_ev_set = bus.wdata[3:0];
			end else if (bus.addr == ICF_RX_EV_CLR) begin
				rx_ev_clr = bus.wdata[3:0];
			end else if (bus.addr == ICF_RX_MK_SET) begin
				rx_mk_set = bus.wdata[3:0];
			end else if (bus.addr == ICF_RX_MK_CLR) begin
				rx_mk_clr = bus.wdata[3:0];
			end else if (bus.addr == ICF_IRQ_STAT) begin
				st_clr_w = bus.wdata[1:0];
			end else if (bus.addr == ICF_IRQ_MASK) begin
				mk_wr = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Context edges and flag banks

	logic [7:0] tx_rise, tx_ev, tx_mk;
	logic [3:0] rx_rise, rx_ev, rx_mk;

	icf_edge #(.N(ICF_TX_N)) u_tx_edge (
		.clock_i (clock_i),
		.rst_b_i (rst_b_i),
		.level_i (tx_irq_i),
		.rise_o  (tx_rise)
	);

	icf_edge #(.N(ICF_RX_N)) u_rx_edge (
		.clock_i (clock_i),
		.rst_b_i (rst_b_i),
		.level_i (rx_irq_i),
		.rise_o  (rx_rise)
	);

	// Tx flags set by last-output completion edges
	icf_flags #(.N(ICF_TX_N)) u_tx_flags (
		.clock_i  (clock_i),
		.rst_b_i  (rst_b_i),
		.hw_set_i (tx_rise),
		.ev_set_i (tx_ev_set),
		.ev_clr_i (tx_ev_clr),
		.mk_set_i (tx_mk_set),
		.mk_clr_i (tx_mk_clr),
		.event_o  (tx_ev),
		.mask_o   (tx_mk)
	);

	// Rx flags set by input completion edges
	icf_flags #(.N(ICF_RX_N)) u_rx_flags (
		.clock_i  (clock_i),
		.rst_b_i  (rst_b_i),
		.hw_set_i (rx_rise),
		.ev_set_i (rx_ev_set),
		.ev_clr_i (rx_ev_clr),
		.mk_set_i (rx_mk_set),
		.mk_clr_i (rx_mk_clr),
		.event_o  (rx_ev),
		.mask_o   (rx_mk)
	);

	////////////////////////////////////////////////////////////////////////////
	// Summaries, block status and read path

	logic        tx_sum, rx_sum;
	logic        tx_sum_q, rx_sum_q;
	logic [1:0]  irq_st, irq_mk;
	logic [1:0]  next_irq_st, next_irq_mk;
	logic [1:0]  sum_rise;
	logic [31:0] rd_mux, next_rdata;
	logic        next_tx_sum_o, next_rx_sum_o, next_irq;
	logic [7:0]  next_main;

	// Masked summaries
	assign tx_sum   = |(tx_ev & tx_mk);
	assign rx_sum   = |(rx_ev & rx_mk);
	assign sum_rise = {rx_sum & ~rx_sum_q, tx_sum & ~tx_sum_q};

	// Read mux, reserved bits zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (bus.addr == ICF_TX_EV_SET) begin
			rd_mux = {24'h00_0000, tx_ev};
		end else if (bus.addr == ICF_TX_EV_CLR) begin
			rd_mux = {24'h00_0000, tx_ev & tx_mk};
		end else if (bus.addr == ICF_TX_MK_SET || bus.addr == ICF_TX_MK_CLR) begin
			rd_mux = {24'h00_0000, tx_mk};
		end else if (bus.addr == ICF_RX_EV_SET) begin
			rd_mux = {28'h000_0000, rx_ev};
		end else if (bus.addr == ICF_RX_EV_CLR) begin
			rd_mux = {28'h000_0000, rx_ev & rx_mk};
		end else if (bus.addr == ICF_RX_MK_SET || bus.addr == ICF_RX_MK_CLR) begin
			rd_mux = {28'h000_0000, rx_mk};
		end else if (bus.addr == ICF_IRQ_STAT) begin
			rd_mux = {30'h0, irq_st};
		end else if (bus.addr == ICF_IRQ_MASK) begin
			rd_mux = {30'h0, irq_mk};
		end
	end

	// Next state of status, mask and outputs
	always_comb begin
		next_irq_st   = (irq_st & ~st_clr_w) | sum_rise;
		next_irq_mk   = mk_wr ? bus.wdata[1:0] : irq_mk;
		next_rdata    = bus.rd ? rd_mux : 32'h0000_0000;
		next_tx_sum_o = tx_sum;
		next_rx_sum_o = rx_sum;
		next_main     = 8'h00;
		next_main[ICF_TX_SUM_BIT] = tx_sum;
		next_main[ICF_RX_SUM_BIT] = rx_sum;
		next_irq      = |(next_irq_st & next_irq_mk);
	end

	// Registers
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_st           <= ICF_IRQ_RST;
			irq_mk           <= ICF_IRQ_RST;
			tx_sum_q         <= 1'b0;
			rx_sum_q         <= 1'b0;
			rdata_o          <= 32'h0000_0000;
			tx_summary_irq_o <= 1'b0;
			rx_summary_irq_o <= 1'b0;
			main_sum_o       <= 8'h00;
			irq_o            <= 1'b0;
		end else begin
			irq_st           <= next_irq_st;
			irq_mk           <= next_irq_mk;
			tx_sum_q         <= tx_sum;
			rx_sum_q         <= rx_sum;
			rdata_o          <= next_rdata;
			tx_summary_irq_o <= next_tx_sum_o;
			rx_summary_irq_o <= next_rx_sum_o;
			main_sum_o       <= next_main;
			irq_o            <= next_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	a_tx_edge_sets: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		$rose(tx_irq_i[0]) |=> tx_ev[0]) else $error("tx edge did not set flag");

	a_clear_only_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(tx_ev[1] && !(bus.wr && bus.addr == ICF_TX_EV_CLR && bus.wdata[1])) |=> tx_ev[1])
		else $error("tx flag lost without clear");

	a_set_beats_clr: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(rx_rise[2] && bus.wr && bus.addr == ICF_RX_EV_CLR) |=> rx_ev[2])
		else $error("event lost on clear");

	a_tx_clr_read: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(bus.rd && bus.addr == ICF_TX_EV_CLR) |=> rdata_o == {24'h00_0000, $past(tx_ev & tx_mk)})
		else $error("tx clear read wrong");

	a_rx_clr_read: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(bus.rd && bus.addr == ICF_RX_EV_CLR) |=> rdata_o == {28'h000_0000, $past(rx_ev & rx_mk)})
		else $error("rx clear read wrong");

	a_tx_mask_read: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(bus.rd && bus.addr == ICF_TX_MK_CLR) |=> rdata_o == {24'h00_0000, $past(tx_mk)})
		else $error("tx mask read wrong");

	a_tx_summary: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		##1 tx_summary_irq_o == $past(|(tx_ev & tx_mk))) else $error("tx summary wrong");

	a_rx_main_bit: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		main_sum_o[7] == rx_summary_irq_o) else $error("rx main bit wrong");

	a_tx_main_bit: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		main_sum_o[6] == tx_summary_irq_o) else $error("tx main bit wrong");

	a_tx_rsvd_zero: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		$past(bus.rd && bus.addr == ICF_TX_EV_SET) |-> rdata_o[31:8] == 24'h00_0000)
		else $error("tx reserved nonzero");

	a_mask_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(bus.wr && bus.addr == ICF_TX_MK_SET) |=> (tx_mk & $past(bus.wdata[7:0])) == $past(bus.wdata[7:0]))
		else $error("tx mask set failed");

	// Clear writes drop every addressed mask bit
	a_tx_mask_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(bus.wr && bus.addr == ICF_TX_MK_CLR) |=> (tx_mk & $past(bus.wdata[7:0])) == 8'h00)
		else $error("tx mask clear failed");

	// Mask moves only on a mask write; a stray change would reroute the summary
	a_tx_mask_stable: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!(bus.wr && (bus.addr == ICF_TX_MK_SET || bus.addr == ICF_TX_MK_CLR))
		|=> $stable(tx_mk))
		else $error("tx mask changed without a write");

	// Both mask addresses read the one stored mask
	a_tx_mask_set_read: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(bus.rd && bus.addr == ICF_TX_MK_SET) |=> rdata_o == {24'h00_0000, $past(tx_mk)})
		else $error("tx mask read at set address wrong");

	// Set addresses show the raw flags, mask ignored
	a_tx_set_read: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(bus.rd && bus.addr == ICF_TX_EV_SET) |=> rdata_o == {24'h00_0000, $past(tx_ev)})
		else $error("tx set read wrong");

	a_rx_set_read: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(bus.rd && bus.addr == ICF_RX_EV_SET) |=> rdata_o == {28'h000_0000, $past(rx_ev)})
		else $error("rx set read wrong");

	// Zero bits of a set write leave flags alone; only an edge may add one
	a_zero_write_keeps: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(bus.wr && bus.addr == ICF_TX_EV_SET && bus.wdata[7:0] == 8'h00)
		|=> (tx_ev & ~$past(tx_rise)) == ($past(tx_ev) & ~$past(tx_rise)))
		else $error("zero set write changed a flag");

	// Receive reads keep the unused upper bits at zero
	a_rx_rsvd_zero: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		$past(bus.rd && (bus.addr == ICF_RX_EV_SET || bus.addr == ICF_RX_EV_CLR))
		|-> rdata_o[31:4] == 28'h000_0000)
		else $error("rx reserved nonzero");

	// Receive summary trails the masked flags by one cycle
	a_rx_summary: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		##1 rx_summary_irq_o == $past(|(rx_ev & rx_mk))) else $error("rx summary wrong");

	// Only bits 6 and 7 of the main layout belong to this block
	a_main_spare_zero: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		main_sum_o[5:0] == 6'h00) else $error("main spare bits nonzero");

	// An all-clear mask keeps the summary quiet whatever the flags hold
	a_tx_no_mask_quiet: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(tx_mk == 8'h00) |=> !tx_summary_irq_o) else $error("tx summary without mask");
	a_rx_no_mask_quiet: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(rx_mk == 4'h0) |=> !rx_summary_irq_o) else $error("rx summary without mask");

	////////////////////////////////////////////////////////////////////////////
	// Per-context assertions, one copy per context

	// Transmit contexts: edge sets, nothing but a clear write takes it away
	for (genvar gi = 0; gi < ICF_TX_N; gi++) begin : g_tx_chk
		a_tx_ctx_set: assert property (@(posedge clock_i) disable iff (!rst_b_i)
			$rose(tx_irq_i[gi]) |=> tx_ev[gi])
			else $error("tx context edge did not set its flag");
		a_tx_ctx_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
			(tx_ev[gi] && !tx_ev_clr[gi]) |=> tx_ev[gi])
			else $error("tx context flag lost without clear");
		a_tx_ctx_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i)
			(tx_ev_clr[gi] && !tx_rise[gi] && !tx_ev_set[gi]) |=> !tx_ev[gi])
			else $error("tx context flag survived clear");
		// A level held high must not look like a fresh edge
		a_tx_ctx_once: assert property (@(posedge clock_i) disable iff (!rst_b_i)
			$past(tx_irq_i[gi]) |-> !tx_rise[gi])
			else $error("held tx level gave a second edge");
	end

	// Receive contexts: same flag behaviour on the input side
	for (genvar gj = 0; gj < ICF_RX_N; gj++) begin : g_rx_chk
		a_rx_ctx_set: assert property (@(posedge clock_i) disable iff (!rst_b_i)
			$rose(rx_irq_i[gj]) |=> rx_ev[gj])
			else $error("rx context edge did not set its flag");
		a_rx_ctx_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
			(rx_ev[gj] && !rx_ev_clr[gj]) |=> rx_ev[gj])
			else $error("rx context flag lost without clear");
		a_rx_ctx_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i)
			(rx_ev_clr[gj] && !rx_rise[gj] && !rx_ev_set[gj]) |=> !rx_ev[gj])
			else $error("rx context flag survived clear");
		// A level held high must not look like a fresh edge
		a_rx_ctx_once: assert property (@(posedge clock_i) disable iff (!rst_b_i)
			$past(rx_irq_i[gj]) |-> !rx_rise[gj])
			else $error("held rx level gave a second edge");
	end

	c_tx_event: cover property (@(posedge clock_i) disable iff (!rst_b_i) $rose(tx_summary_irq_o));
	c_rx_event: cover property (@(posedge clock_i) disable iff (!rst_b_i) $rose(rx_summary_irq_o));
	c_irq_out:  cover property (@(posedge clock_i) disable iff (!rst_b_i) $rose(irq_o));
	c_clr_read: cover property (@(posedge clock_i) disable iff (!rst_b_i)
		bus.rd && bus.addr == ICF_TX_EV_CLR && |(tx_ev & tx_mk));
	c_set_clr_clash: cover property (@(posedge clock_i) disable iff (!rst_b_i)
		|rx_rise && bus.wr && bus.addr == ICF_RX_EV_CLR);

endmodule : icf_top
`default_nettype wire

// ---- rtl/icf_pkg.sv ----
// Package: offsets, widths, reset values and carrier struct for the iso context flags
package icf_pkg;

	localparam int unsigned ICF_AW        = 8;
	localparam int unsigned ICF_DW        = 32;
	localparam int unsigned ICF_TX_N      = 8;
	localparam int unsigned ICF_RX_N      = 4;

	// Register byte addresses
	localparam logic [7:0] ICF_TX_EV_SET  = 8'h90;
	localparam logic [7:0] ICF_TX_EV_CLR  = 8'h94;
	localparam logic [7:0] ICF_TX_MK_SET  = 8'h98;
	localparam logic [7:0] ICF_TX_MK_CLR  = 8'h9C;
	localparam logic [7:0] ICF_RX_EV_SET  = 8'hA0;
	localparam logic [7:0] ICF_RX_EV_CLR  = 8'hA4;
	// Receive mask and block interrupt status/mask (own placement)
	localparam logic [7:0] ICF_RX_MK_SET  = 8'hA8;
	localparam logic [7:0] ICF_RX_MK_CLR  = 8'hAC;
	localparam logic [7:0] ICF_IRQ_STAT   = 8'hC0;
	localparam logic [7:0] ICF_IRQ_MASK   = 8'hC4;

	// Summary bit positions in the main event layout
	localparam int unsigned ICF_TX_SUM_BIT = 6;
	localparam int unsigned ICF_RX_SUM_BIT = 7;

	// Reset values
	localparam logic [7:0] ICF_TX_RST     = 8'h00;
	localparam logic [3:0] ICF_RX_RST     = 4'h0;
	localparam logic [1:0] ICF_IRQ_RST    = 2'h0;

	// Register bus request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} icf_bus_s;

endpackage : icf_pkg

// ---- rtl/icf_edge.sv ----
// Rising edge detector on same-clock context interrupt lines
`timescale 1ns/100ps
`default_nettype none
module icf_edge import icf_pkg::*; #(
	parameter int unsigned N = 8
) (
	input  wire logic         clock_i,  // Clock
	input  wire logic         rst_b_i,  // Async reset, active low
	input  wire logic [N-1:0] level_i,  // Context interrupt levels
	output logic      [N-1:0] rise_o    // One-cycle rise pulses
);

	logic [N-1:0] prev;
	logic [N-1:0] next_prev;

	// Next value of delayed level
	always_comb begin
		next_prev = level_i;
	end

	// Delayed copy
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prev <= '0;
		end else begin
			prev <= next_prev;
		end
	end

	// Pulse on asserting edge
	assign rise_o = level_i & ~prev;

endmodule : icf_edge
`default_nettype wire

// ---- rtl/icf_flags.sv ----
// Set/clear flag and mask bank for one direction of contexts
`timescale 1ns/100ps
`default_nettype none
module icf_flags import icf_pkg::*; #(
	parameter int unsigned N = 8
) (
	input  wire logic         clock_i,   // Clock
	input  wire logic         rst_b_i,   // Async reset, active low
	input  wire logic [N-1:0] hw_set_i,  // Hardware event pulses
	input  wire logic [N-1:0] ev_set_i,  // Software event set bits
	input  wire logic [N-1:0] ev_clr_i,  // Software event clear bits
	input  wire logic [N-1:0] mk_set_i,  // Mask set bits
	input  wire logic [N-1:0] mk_clr_i,  // Mask clear bits
	output logic      [N-1:0] event_o,   // Event flags
	output logic      [N-1:0] mask_o     // Mask bits
);

	logic [N-1:0] next_event;
	logic [N-1:0] next_mask;

	// Per-bit set-wins update
	always_comb begin
		next_event = (event_o & ~ev_clr_i) | hw_set_i | ev_set_i;
		next_mask  = (mask_o & ~mk_clr_i) | mk_set_i;
	end

	// Flag storage
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			event_o <= '0;
			mask_o  <= '0;
		end else begin
			event_o <= next_event;
			mask_o  <= next_mask;
		end
	end

endmodule : icf_flags
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the iso context interrupt flag block
`timescale 1ns/100ps
`default_nettype none
module tb import icf_pkg::*; ;
	logic        clock_i;
	logic        rst_b_i;
	logic [7:0]  addr_i;
	logic [31:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [31:0] rdata_o;
	logic [7:0]  tx_irq_i;
	logic [3:0]  rx_irq_i;
	logic        tx_summary_irq_o;
	logic        rx_summary_irq_o;
	logic [7:0]  main_sum_o;
	logic        irq_o;
	logic [7:0]  m_tx_ev, m_tx_mk;
	logic [3:0]  m_rx_ev, m_rx_mk;
	logic [31:0] lfsr, v;
	int          errors, total_checks;
	logic [7:0]  map_a [10] = '{ICF_TX_EV_SET, ICF_TX_EV_CLR, ICF_TX_MK_SET, ICF_TX_MK_CLR,
		ICF_RX_EV_SET, ICF_RX_EV_CLR, ICF_RX_MK_SET, ICF_RX_MK_CLR, 8'h50, 8'hB0};

	icf_top i_icf_top (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_irq_i(tx_irq_i), .rx_irq_i(rx_irq_i),
		.tx_summary_irq_o(tx_summary_irq_o), .rx_summary_irq_o(rx_summary_irq_o),
		.main_sum_o(main_sum_o), .irq_o(irq_o));

	// Clock, 5 ns period
	always #2.5 clock_i = ~clock_i;

	////////////////////////////////////////////////////////////////////////////////
	// Reference model and helpers
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
	endfunction : next_rand

	function automatic logic [31:0] expect_rd(input logic [7:0] a);
		case (a)
			ICF_TX_EV_SET: return {24'h0, m_tx_ev};
			ICF_TX_EV_CLR: return {24'h0, m_tx_ev & m_tx_mk};
			ICF_TX_MK_SET, ICF_TX_MK_CLR: return {24'h0, m_tx_mk};
			ICF_RX_EV_SET: return {28'h0, m_rx_ev};
			ICF_RX_EV_CLR: return {28'h0, m_rx_ev & m_rx_mk};
			ICF_RX_MK_SET, ICF_RX_MK_CLR: return {28'h0, m_rx_mk};
			default: return 32'h0;
		endcase
	endfunction : expect_rd

	task automatic model_wr(input logic [7:0] a, input logic [31:0] d);
		case (a)
			ICF_TX_EV_SET: m_tx_ev |= d[7:0];
			ICF_TX_EV_CLR: m_tx_ev &= ~d[7:0];
			ICF_TX_MK_SET: m_tx_mk |= d[7:0];
			ICF_TX_MK_CLR: m_tx_mk &= ~d[7:0];
			ICF_RX_EV_SET: m_rx_ev |= d[3:0];
			ICF_RX_EV_CLR: m_rx_ev &= ~d[3:0];
			ICF_RX_MK_SET: m_rx_mk |= d[3:0];
			ICF_RX_MK_CLR: m_rx_mk &= ~d[3:0];
			default: ;
		endcase
	endtask : model_wr

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
		model_wr(a, d);
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : bus_rd

	// One-cycle context pulses, back to low
	task automatic pulse(input logic [7:0] t, input logic [3:0] r);
		@(posedge clock_i);
		tx_irq_i <= t;
		rx_irq_i <= r;
		@(posedge clock_i);
		tx_irq_i <= 8'h00;
		rx_irq_i <= 4'h0;
		m_tx_ev |= t;
		m_rx_ev |= r;
	endtask : pulse

	// Read the eight flag and mask places, two unused addresses and the summaries
	task automatic chk_all();
		logic [31:0] d;
		for (int i = 0; i < 10; i++) begin
			bus_rd(map_a[i], d);
			check($sformatf("read %h", map_a[i]), expect_rd(map_a[i]), d);
		end
		check("tx summary", {31'h0, |(m_tx_ev & m_tx_mk)}, {31'h0, tx_summary_irq_o});
		check("rx summary", {31'h0, |(m_rx_ev & m_rx_mk)}, {31'h0, rx_summary_irq_o});
		check("main sum", {24'h0, |(m_rx_ev & m_rx_mk), |(m_tx_ev & m_tx_mk), 6'h0},
			{24'h0, main_sum_o});
	endtask : chk_all

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog, far beyond the expected few thousand cycles
	initial begin
		#(50000 * 5);
		errors++;
		complete_run();
	end

	// Main sequence
	initial begin
		clock_i = 1'b0;
		rst_b_i = 1'b0;
		{addr_i, wdata_i, wr_i, rd_i, tx_irq_i, rx_irq_i} = '0;
		{m_tx_ev, m_tx_mk, m_rx_ev, m_rx_mk} = '0;
		lfsr = 32'h9DD54019;
		errors = 0;
		total_checks = 0;
		repeat (6) @(posedge clock_i);
		rst_b_i <= 1'b1;
		chk_all();
		$display("test reset_values done");
		// Random writes, pulses and full readback
		for (int i = 0; i < 60; i++) begin
			lfsr = next_rand(lfsr);
			v = lfsr;
			lfsr = next_rand(lfsr);
			bus_wr(map_a[v[7:0] % 10], (i % 7 == 0) ? 32'hFFFFFFFF : lfsr);
			lfsr = next_rand(lfsr);
			pulse(lfsr[7:0] & lfsr[15:8], lfsr[19:16] & lfsr[23:20]);
			chk_all();
			check("irq masked off", 32'h0, {31'h0, irq_o});
		end
		$display("test random_access done");
		// Held-high input sets only once
		bus_wr(ICF_TX_EV_CLR, 32'hFF);
		bus_wr(ICF_RX_EV_CLR, 32'hF);
		@(posedge clock_i);
		tx_irq_i <= 8'h81;
		rx_irq_i <= 4'h8;
		repeat (2) @(posedge clock_i);
		m_tx_ev |= 8'h81;
		m_rx_ev |= 4'h8;
		chk_all();
		bus_wr(ICF_TX_EV_CLR, 32'h81);
		bus_wr(ICF_RX_EV_CLR, 32'h8);
		chk_all();
		@(posedge clock_i);
		tx_irq_i <= 8'h00;
		rx_irq_i <= 4'h0;
		$display("test held_high done");
		// Per-context summary, status and block interrupt
		bus_wr(ICF_TX_MK_CLR, 32'hFF);
		bus_wr(ICF_RX_MK_CLR, 32'hF);
		bus_wr(ICF_IRQ_STAT, 32'h3);
		bus_wr(ICF_IRQ_MASK, 32'h3);
		for (int k = 0; k < 12; k++) begin
			bus_wr(k < 8 ? ICF_TX_MK_SET : ICF_RX_MK_SET, 32'h1 << (k % 8));
			pulse(k < 8 ? 8'h1 << k : 8'h0, k < 8 ? 4'h0 : 4'h1 << (k - 8));
			@(posedge clock_i);
			#1;
			check("main sum late", k < 8 ? 32'h40 : 32'h80, {24'h0, main_sum_o});
			check("block irq", 32'h1, {31'h0, irq_o});
			bus_rd(ICF_IRQ_STAT, v);
			check("status", k < 8 ? 32'h1 : 32'h2, v);
			bus_wr(ICF_IRQ_STAT, 32'h3);
			bus_wr(k < 8 ? ICF_TX_EV_CLR : ICF_RX_EV_CLR, 32'h1 << (k % 8));
			bus_wr(k < 8 ? ICF_TX_MK_CLR : ICF_RX_MK_CLR, 32'h1 << (k % 8));
			chk_all();
			check("irq cleared", 32'h0, {31'h0, irq_o});
		end
		$display("test summary_status done");
		// Edge and clear write on one edge: the edge wins
		bus_wr(ICF_RX_MK_SET, 32'h4);
		@(posedge clock_i);
		rx_irq_i <= 4'h4;
		addr_i   <= ICF_RX_EV_CLR;
		wdata_i  <= 32'hF;
		wr_i     <= 1'b1;
		@(posedge clock_i);
		wr_i     <= 1'b0;
		rx_irq_i <= 4'h0;
		model_wr(ICF_RX_EV_CLR, 32'hF);
		m_rx_ev |= 4'h4;
		chk_all();
		// Zero bits and reserved bits of writes do nothing
		bus_wr(ICF_TX_EV_SET, 32'hFFFF_FF00);
		bus_wr(ICF_RX_EV_SET, 32'hFFFF_FFF0);
		bus_wr(ICF_RX_EV_CLR, 32'h0000_0000);
		chk_all();
		// Reset in mid-run drops every flag, mask and output
		@(posedge clock_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		rst_b_i <= 1'b1;
		{m_tx_ev, m_tx_mk, m_rx_ev, m_rx_mk} = '0;
		chk_all();
		check("irq after reset", 32'h0, {31'h0, irq_o});
		$display("test corner_cases done");
		complete_run();
	end
endmodule : tb
`default_nettype wire
